// ===== hw/jog_axis.sv
// one geometry axis: selection check, step motion, status bytes
`timescale 1ns/10ps
module jog_axis
  import jog_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  axis_if.axis     a
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_STEP = 3'b010,
    ST_CONT = 3'b100
  } mot_e;

  mot_e        state_q;
  mot_e        state_d;
  logic [6:0]  sel_last_q;
  logic [7:0]  remain_q;
  logic [7:0]  remain_d;
  logic        dir_q;
  logic        dir_d;
  logic        kp_q;
  logic        km_q;

  // ---------------------------------------------
  // selection decode
  // ---------------------------------------------
  wire [6:0] sel7      = a.sel[6:0];
  // R06: more than one bit means nothing active
  wire       one_hot   = (sel7 != 7'h00) && ((sel7 & (sel7 - 7'h01)) == 7'h00);
  // R02: jog mode or handwheel offset
  wire       mode_ok   = a.jog_mode | a.ofs_mode;
  wire       valid     = one_hot && mode_ok && (!sel7[BIT_CONT] || a.jog_mode);
  // R13: invalid clears every active bit
  wire [6:0] active    = valid ? sel7 : 7'h00;
  // R12: both keys means no motion
  wire       both      = a.key_plus & a.key_minus;
  wire       kp_rise   = a.key_plus & ~kp_q & ~a.key_minus;
  wire       km_rise   = a.key_minus & ~km_q & ~a.key_plus;
  wire       hw_start  = a.hw_detent & ~both;
  // R07: change of selection aborts step
  wire       sel_chg   = sel_last_q != active;

  // R03 R04: step distance from table or variable size
  function automatic logic [7:0] step_dist(input logic [6:0] s);
    logic [7:0] d;
    d = 8'h00;
    for (int i = 0; i < NUM_STEPS; i++) begin
      if (s[i]) begin
        d = a.step_tab[i];
      end
    end
    if (s[BIT_VAR]) begin
      d = a.var_step;
    end
    return d;
  endfunction

  always_comb begin
    state_d  = state_q;
    remain_d = remain_q;
    dir_d    = dir_q;
    unique case (state_q)
      ST_IDLE: begin
        // R08: continuous jogging with keys
        if (active[BIT_CONT] && (kp_rise || km_rise)) begin
          state_d = ST_CONT;
          dir_d   = kp_rise;
        end else if (active[5:0] != 6'h00 && (kp_rise || km_rise || hw_start)) begin
          // R01: selected step size is the move
          state_d  = ST_STEP;
          dir_d    = hw_start ? 1'b1 : kp_rise;
          remain_d = step_dist(active);
        end
      end
      ST_STEP: begin
        if (sel_chg || both || remain_q <= 8'h01) begin
          state_d  = ST_IDLE;
          remain_d = 8'h00;
        end else begin
          remain_d = remain_q - 8'h01;
        end
      end
      ST_CONT: begin
        if (sel_chg || both || (dir_q ? !a.key_plus : !a.key_minus)) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= ST_IDLE;
      remain_q   <= 8'h00;
      dir_q      <= 1'b0;
      sel_last_q <= 7'h00;
      kp_q       <= 1'b0;
      km_q       <= 1'b0;
    end else begin
      state_q    <= state_d;
      remain_q   <= remain_d;
      dir_q      <= dir_d;
      sel_last_q <= active;
      kp_q       <= a.key_plus;
      km_q       <= a.key_minus;
    end
  end

  // ---------------------------------------------
  // status bytes
  // ---------------------------------------------
  wire moving = state_q != ST_IDLE;
  // R10: motion status layout
  assign a.mot_status = {moving & dir_q, moving & ~dir_q,
                         a.key_plus & ~both, a.key_minus & ~both, 1'b0, a.hw_active};
  // R05 R11: active function layout
  assign a.act_status = {1'b0, sel_last_q};
endmodule

// ===== hw/jog_increment_select.sv
// channel jog step selection with register port
//
// The strobed register port was left to the implementer.
`timescale 1ns/10ps
module jog_increment_select
  import jog_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic [2:0] key_plus_pin,
  input  wire logic [2:0] key_minus_pin,
  input  wire logic [2:0] hw_detent_pin,
  input  wire logic [8:0] hw_active_pin,
  input  wire logic [7:0] panel_pin,
  input  wire logic [7:0] hw_flags_pin,
  input  wire logic [7:0] misc_pin,
  output logic      [2:0] axis_moving
);
  // ---------------------------------------------
  // pin synchronisers
  // ---------------------------------------------
  logic [41:0] pin_s1_q;
  logic [41:0] pin_s2_q;
  wire  [41:0] pin_raw = {misc_pin, hw_flags_pin, panel_pin, hw_active_pin,
                          hw_detent_pin, key_minus_pin, key_plus_pin};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 42'h0;
      pin_s2_q <= 42'h0;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
    end
  end

  wire [2:0] kp_s   = pin_s2_q[2:0];
  wire [2:0] km_s   = pin_s2_q[5:3];
  wire [2:0] hd_s   = pin_s2_q[8:6];
  wire [8:0] ha_s   = pin_s2_q[17:9];
  wire [7:0] pan_s  = pin_s2_q[25:18];
  wire [7:0] hwf_s  = pin_s2_q[33:26];
  wire [7:0] misc_s = pin_s2_q[41:34];

  // ---------------------------------------------
  // writable registers
  // ---------------------------------------------
  logic [7:0] sel_q   [0:NUM_AXES-1];
  logic [7:0] tab_q   [0:NUM_STEPS-1];
  logic [7:0] var_q;
  logic [7:0] mode_q;

  function automatic logic [7:0] sel_ofs(input int i);
    return (i == 0) ? OFS_AX1_SEL : (i == 1) ? OFS_AX2_SEL : OFS_AX3_SEL;
  endfunction

  function automatic logic [7:0] tab_rst(input int i);
    return (i == 0) ? RST_TAB0 : (i == 1) ? RST_TAB1 : (i == 2) ? RST_TAB2 :
           (i == 3) ? RST_TAB3 : RST_TAB4;
  endfunction

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_AXES; i++) begin
        sel_q[i] <= RST_SEL;
      end
      for (int i = 0; i < NUM_STEPS; i++) begin
        tab_q[i] <= tab_rst(i);
      end
      var_q  <= RST_VAR_STEP;
      mode_q <= RST_MODE;
    end else if (reg_wr) begin
      // R09: controller refreshes selection bytes
      for (int i = 0; i < NUM_AXES; i++) begin
        if (reg_addr == sel_ofs(i)) begin
          sel_q[i] <= reg_wdata;
        end
      end
      // R03: shared step table
      for (int i = 0; i < NUM_STEPS; i++) begin
        if (reg_addr == OFS_TAB0 + 8'(i)) begin
          tab_q[i] <= reg_wdata;
        end
      end
      // R04: variable step size
      if (reg_addr == OFS_VAR_STEP) begin
        var_q <= reg_wdata;
      end
      if (reg_addr == OFS_MODE) begin
        mode_q <= reg_wdata;
      end
    end
  end

  // ---------------------------------------------
  // axes
  // ---------------------------------------------
  logic [7:0] mot_w [0:NUM_AXES-1];
  logic [7:0] act_w [0:NUM_AXES-1];

  for (genvar g = 0; g < NUM_AXES; g++) begin : gen_axis
    axis_if ax ();
    assign ax.sel       = sel_q[g];
    assign ax.step_tab  = tab_q;
    assign ax.var_step  = var_q;
    assign ax.jog_mode  = mode_q[BIT_MODE_JOG];
    assign ax.ofs_mode  = mode_q[BIT_MODE_OFS];
    assign ax.key_plus  = kp_s[g];
    assign ax.key_minus = km_s[g];
    assign ax.hw_active = ha_s[3*g +: 3];
    assign ax.hw_detent = hd_s[g];
    assign mot_w[g]     = ax.mot_status;
    assign act_w[g]     = ax.act_status;
    jog_axis jog_axis_i (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .a       (ax)
    );
  end

  // ---------------------------------------------
  // read mux
  // ---------------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (reg_addr)
      OFS_AX1_SEL:  rd_mux = sel_q[0];
      OFS_AX2_SEL:  rd_mux = sel_q[1];
      OFS_AX3_SEL:  rd_mux = sel_q[2];
      OFS_PANEL:    rd_mux = pan_s;
      OFS_HW_FLAGS: rd_mux = hwf_s;
      OFS_MISC:     rd_mux = misc_s;
      OFS_AX1_MOT:  rd_mux = mot_w[0];
      OFS_AX1_ACT:  rd_mux = act_w[0];
      OFS_AX2_MOT:  rd_mux = mot_w[1];
      OFS_AX2_ACT:  rd_mux = act_w[1];
      OFS_AX3_MOT:  rd_mux = mot_w[2];
      OFS_AX3_ACT:  rd_mux = act_w[2];
      OFS_VAR_STEP: rd_mux = var_q;
      OFS_MODE:     rd_mux = mode_q;
      default: begin
        for (int i = 0; i < NUM_STEPS; i++) begin
          if (reg_addr == OFS_TAB0 + 8'(i)) begin
            rd_mux = tab_q[i];
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata   <= 8'h00;
      axis_moving <= 3'b000;
    end else begin
      reg_rdata   <= reg_rd ? rd_mux : 8'h00;
      axis_moving <= {mot_w[2][BIT_MOT_CMD_P] | mot_w[2][BIT_MOT_CMD_M],
                      mot_w[1][BIT_MOT_CMD_P] | mot_w[1][BIT_MOT_CMD_M],
                      mot_w[0][BIT_MOT_CMD_P] | mot_w[0][BIT_MOT_CMD_M]};
    end
  end
endmodule

// ===== include/axis_if.sv
// per-axis selection and status bundle
`timescale 1ns/10ps
interface axis_if;
  logic [7:0] sel;
  logic [7:0] step_tab [0:4];
  logic [7:0] var_step;
  logic       jog_mode;
  logic       ofs_mode;
  logic       key_plus;
  logic       key_minus;
  logic [2:0] hw_active;
  logic       hw_detent;
  logic [7:0] mot_status;
  logic [7:0] act_status;
  modport ctrl (output sel, step_tab, var_step, jog_mode, ofs_mode, key_plus, key_minus,
                hw_active, hw_detent, input mot_status, act_status);
  modport axis (input sel, step_tab, var_step, jog_mode, ofs_mode, key_plus, key_minus,
                hw_active, hw_detent, output mot_status, act_status);
endinterface

// ===== include/jog_pkg.sv
// constants for jog step selection
// Operation
// R01: selection bits 0..5 pick step one, ten, hundred, thousand, ten thousand, variable
// R02: step selection only applies in jog mode, except with handwheel position offset
// R03: fixed step distances come from shared step size table
// R04: variable step uses separately configured variable step size
// R05: effective selection sets matching bit in active-function status byte
// R06: several selection bits set at once activates no function for that axis
// R07: clearing or changing selection aborts a step in progress
// R08: bit 6 selects continuous jogging with plus/minus keys in jog mode
// R09: controller writes axis selections to bytes 13, 17, 21 cyclically
// R10: motion status: command plus/minus bits 7/6, request 5/4, handwheels bits 2..0
// R11: active status: continuous bit 6, variable bit 5, steps bits 4..0
// R12: plus and minus together start nothing and abort any motion
// R13: invalid or absent selection clears all active-function bits
package jog_pkg;
  localparam logic [7:0] OFS_AX1_SEL   = 8'h0D;
  localparam logic [7:0] OFS_AX2_SEL   = 8'h11;
  localparam logic [7:0] OFS_AX3_SEL   = 8'h15;
  localparam logic [7:0] OFS_PANEL     = 8'h18;
  localparam logic [7:0] OFS_HW_FLAGS  = 8'h21;
  localparam logic [7:0] OFS_MISC      = 8'h25;
  localparam logic [7:0] OFS_AX1_MOT   = 8'h28;
  localparam logic [7:0] OFS_AX1_ACT   = 8'h29;
  localparam logic [7:0] OFS_AX2_MOT   = 8'h2E;
  localparam logic [7:0] OFS_AX2_ACT   = 8'h2F;
  localparam logic [7:0] OFS_AX3_MOT   = 8'h34;
  localparam logic [7:0] OFS_AX3_ACT   = 8'h35;
  localparam logic [7:0] OFS_TAB0      = 8'h60;
  localparam logic [7:0] OFS_VAR_STEP  = 8'h65;
  localparam logic [7:0] OFS_MODE      = 8'h66;
  localparam int         BIT_CONT      = 6;
  localparam int         BIT_VAR       = 5;
  localparam int         BIT_MOT_CMD_P = 7;
  localparam int         BIT_MOT_CMD_M = 6;
  localparam int         BIT_MOT_REQ_P = 5;
  localparam int         BIT_MOT_REQ_M = 4;
  localparam int         BIT_MODE_JOG  = 0;
  localparam int         BIT_MODE_OFS  = 1;
  localparam logic [7:0] RST_SEL       = 8'h00;
  localparam logic [7:0] RST_TAB0      = 8'h01;
  localparam logic [7:0] RST_TAB1      = 8'h0A;
  localparam logic [7:0] RST_TAB2      = 8'h64;
  localparam logic [7:0] RST_TAB3      = 8'hFF;
  localparam logic [7:0] RST_TAB4      = 8'hFF;
  localparam logic [7:0] RST_VAR_STEP  = 8'h05;
  localparam logic [7:0] RST_MODE      = 8'h00;
  localparam int         NUM_AXES      = 3;
  localparam int         NUM_STEPS     = 5;
endpackage

// ===== verification/jog_increment_select_monitor.sv
// port assertions for the jog step selection block
`timescale 1ns/10ps
module jog_increment_select_monitor
  import jog_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [2:0] key_plus_pin,
  input wire logic [2:0] key_minus_pin,
  input wire logic [2:0] hw_detent_pin,
  input wire logic [2:0] axis_moving
);
  // ----
  // checks
  // ----
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire cause0 = key_plus_pin[0] | key_minus_pin[0] | hw_detent_pin[0];
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  AST_UNMAPPED: assert property ($past(reg_rd) && $past(reg_addr) == 8'h00 |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_SEL_READBACK: assert property (reg_wr && reg_addr == OFS_AX1_SEL ##2 reg_rd && !$past(reg_wr)
    && reg_addr == OFS_AX1_SEL |=> reg_rdata == $past(reg_wdata, 3))
    else $error("selection readback wrong");
  AST_ACT_ONEHOT: assert property ($past(reg_rd) && $past(reg_addr) == OFS_AX1_ACT
    |-> $onehot0(reg_rdata) && !reg_rdata[7])
    else $error("active status not one-hot");
  AST_CMD_EXCL: assert property ($past(reg_rd) && $past(reg_addr) == OFS_AX1_MOT
    |-> !(reg_rdata[BIT_MOT_CMD_P] && reg_rdata[BIT_MOT_CMD_M]))
    else $error("both motion commands set");
  AST_REQ_EXCL: assert property ($past(reg_rd) && $past(reg_addr) == OFS_AX1_MOT
    |-> !(reg_rdata[BIT_MOT_REQ_P] && reg_rdata[BIT_MOT_REQ_M]))
    else $error("both travel requests set");
  AST_BOTH_KEYS: assert property ((key_plus_pin[0] && key_minus_pin[0])[*6] |-> !axis_moving[0])
    else $error("axis moves with both keys");
  AST_MOVE_CAUSE: assert property ($rose(axis_moving[0])
    |-> $past(cause0, 2) || $past(cause0, 3) || $past(cause0, 4) || $past(cause0, 5))
    else $error("motion without key or detent");
endmodule
bind jog_increment_select jog_increment_select_monitor jog_increment_select_monitor_i (
  .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .key_plus_pin(key_plus_pin), .key_minus_pin(key_minus_pin),
  .hw_detent_pin(hw_detent_pin), .axis_moving(axis_moving));

// ===== verification/jog_increment_select_tb.sv
// self-checking bench for the jog step selection block
`timescale 1ns/10ps
module jog_increment_select_tb;
  import jog_pkg::*;
  logic       sys_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [2:0] kp = '0, km = '0, hd = '0, mv;
  logic [8:0] hwa = 9'o536;
  logic [7:0] addr, wdata, rdata;
  logic       wr, rd;
  int         n_fail = 0, comparisons = 0, n;
  logic [7:0] tab_rst [5] = '{RST_TAB0, RST_TAB1, RST_TAB2, RST_TAB3, RST_TAB4};
  logic [7:0] sel_ofs [3] = '{OFS_AX1_SEL, OFS_AX2_SEL, OFS_AX3_SEL};
  logic [7:0] act_ofs [3] = '{OFS_AX1_ACT, OFS_AX2_ACT, OFS_AX3_ACT};
  logic [7:0] mot_ofs [3] = '{OFS_AX1_MOT, OFS_AX2_MOT, OFS_AX3_MOT};
  initial forever #12.5 sys_clk = ~sys_clk;
  plc_model plc_model_i (.sys_clk(sys_clk), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdata));
  jog_increment_select jog_increment_select_i (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(addr),
    .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .key_plus_pin(kp), .key_minus_pin(km),
    .hw_detent_pin(hd), .hw_active_pin(hwa), .panel_pin(8'h5A), .hw_flags_pin(8'hC3), .misc_pin(8'h96),
    .axis_moving(mv));
  // ----
  // helpers
  // ----
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("mismatches %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge sys_clk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    plc_model_i.rd(a, d);
    check(d, exp);
  endtask
  // pulse a detent and count the cycles the axis moves
  task automatic run_len(input int ax);
    n = 0;
    @(posedge sys_clk);
    hd[ax] <= 1'b1;
    @(posedge sys_clk);
    hd[ax] <= 1'b0;
    repeat (20) if (!mv[ax]) @(negedge sys_clk);
    while (mv[ax] && n < 600) begin
      @(negedge sys_clk);
      n++;
    end
  endtask
  initial begin
    cyc(20000);
    n_fail++;
    conclude();
  end
  // ----
  // scenarios
  // ----
  initial begin
    cyc(16);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) rchk(OFS_TAB0 + 8'(i), tab_rst[i]);
    rchk(OFS_VAR_STEP, RST_VAR_STEP);
    rchk(OFS_MODE, RST_MODE);
    rchk(8'h00, 8'h00);
    plc_model_i.wr(OFS_PANEL, 8'h00);
    rchk(OFS_PANEL, 8'h5A);
    rchk(OFS_HW_FLAGS, 8'hC3);
    rchk(OFS_MISC, 8'h96);
    for (int a = 0; a < 3; a++) rchk(mot_ofs[a], {5'h00, hwa[3*a +: 3]});
    @(posedge sys_clk);
    hwa <= 9'h000;
    plc_model_i.wr(OFS_MODE, 8'h01);
    for (int a = 0; a < 3; a++) begin
      rchk(sel_ofs[a], RST_SEL);
      for (int i = 0; i < 7; i++) begin
        plc_model_i.wr(sel_ofs[a], 8'h01 << i);
        rchk(act_ofs[a], 8'h01 << i);
      end
      plc_model_i.wr(sel_ofs[a], 8'h41);
      rchk(sel_ofs[a], 8'h41);
      rchk(act_ofs[a], 8'h00);
      plc_model_i.wr(sel_ofs[a], 8'h00);
      rchk(act_ofs[a], 8'h00);
    end
    plc_model_i.wr(OFS_TAB0 + 8'h03, 8'h07);
    plc_model_i.wr(OFS_AX1_SEL, 8'h08);
    run_len(0);
    check(8'(n), 8'h07);
    plc_model_i.wr(OFS_VAR_STEP, 8'h04);
    plc_model_i.wr(OFS_AX1_SEL, 8'h20);
    run_len(0);
    check(8'(n), 8'h04);
    plc_model_i.wr(OFS_MODE, 8'h00);
    run_len(0);
    check(8'(n), 8'h00);
    plc_model_i.wr(OFS_MODE, 8'h02);
    run_len(0);
    check(8'(n), 8'h04);
    plc_model_i.wr(OFS_MODE, 8'h01);
    plc_model_i.wr(OFS_AX1_SEL, 8'h10);
    kp[0] <= 1'b1;
    cyc(6);
    rchk(OFS_AX1_MOT, 8'hA0);
    plc_model_i.wr(OFS_AX1_SEL, 8'h01);
    cyc(4);
    @(negedge sys_clk);
    check({7'h00, mv[0]}, 8'h00);
    @(posedge sys_clk);
    kp[0] <= 1'b0;
    plc_model_i.wr(OFS_AX1_SEL, 8'h40);
    kp[0] <= 1'b1;
    cyc(6);
    rchk(OFS_AX1_ACT, 8'h40);
    check({7'h00, mv[0]}, 8'h01);
    @(posedge sys_clk);
    km[0] <= 1'b1;
    cyc(8);
    rchk(OFS_AX1_MOT, 8'h00);
    check({7'h00, mv[0]}, 8'h00);
    @(posedge sys_clk);
    kp[0] <= 1'b0;
    km[0] <= 1'b0;
    cyc(4);
    km[0] <= 1'b1;
    cyc(6);
    rchk(OFS_AX1_MOT, 8'h50);
    check({7'h00, mv[0]}, 8'h01);
    @(posedge sys_clk);
    km[0] <= 1'b0;
    conclude();
  end
endmodule

// ===== verification/plc_model.sv
// register bus master standing in for the controller program
`timescale 1ns/10ps
module plc_model (
  input  wire logic       sys_clk,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  // ----
  // bus cycles
  // ----
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask
endmodule
